// File: verif/core_access_model.sv
// core model issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module core_access_model
(
	input wire logic clk_sys,
	input wire logic [7:0] sfr_rdata,
	output logic sfr_rd, sfr_wr, sfr_bit,
	output logic [2:0] sfr_bit_sel,
	output logic [7:0] sfr_addr, sfr_wdata
);
	initial {sfr_rd, sfr_wr, sfr_bit, sfr_bit_sel, sfr_addr, sfr_wdata} = '0;
	// plain accesses, no flash erase or write
	task automatic acc(input logic r, w, b, input logic [2:0] s,
		input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clk_sys);
		{sfr_rd, sfr_wr, sfr_bit, sfr_bit_sel, sfr_addr, sfr_wdata} =
			{r, w, b, s, a, d};
		@(negedge clk_sys);
		q = sfr_rdata;
		{sfr_rd, sfr_wr, sfr_bit} = 3'h0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// File: verif/sfr_memory_map_decode_assertions.sv
// assertions on the register bank decode ports
`timescale 1ns/1ns
`default_nettype none
module sfr_memory_map_decode_assertions
	import sfr_map_pkg::*;
(
	input wire logic clk_sys, reset, flash_32k, xaddr_valid, sfr_wr,
	input wire logic sfr_rd, sfr_bit, sfr_hit, sfr_bit_err, idata_sel,
	input wire logic [ADDR_W-1:0] xaddr,
	input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
	input wire logic [7:0] memory_cycle_control, clock_control_reg,
	input wire logic [7:0] flash_command_reg,
	input wire logic [2:0] xspace
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire acc = sfr_rd | sfr_wr;
	property p_rst; disable iff (1'b0) reset |=> memory_cycle_control == 8'h01
		&& clock_control_reg == 8'h80 && flash_command_reg == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_unmap; sfr_rd && sfr_addr == 8'h84 |=> sfr_rdata == 8'h00
		&& !sfr_hit; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_berr; acc && sfr_bit && sfr_addr[2:0] != 3'h0 |=> sfr_bit_err;
		endproperty
	a_berr: assert property (p_berr) else $error("bit access taken");
	property p_bok; acc && sfr_bit && sfr_addr[2:0] == 3'h0 |=> !sfr_bit_err;
		endproperty
	a_bok: assert property (p_bok) else $error("bit access refused");
	property p_fcmd; sfr_wr && !sfr_bit && sfr_addr == 8'hfa |=>
		flash_command_reg == $past(sfr_wdata); endproperty
	a_fcmd: assert property (p_fcmd) else $error("flash command");
	property p_idat; acc |=> idata_sel == ($past(sfr_addr) < 8'h80); endproperty
	a_idat: assert property (p_idat) else $error("idata select");
	property p_flash; xaddr_valid && (xaddr <= 16'h3fff || flash_32k &&
		xaddr <= 16'h7fff) |=> xspace == 3'h1; endproperty
	a_flash: assert property (p_flash) else $error("flash space");
	property p_usb; xaddr_valid && xaddr[15:11] == 5'h18 |=> xspace == 3'h3;
		endproperty
	a_usb: assert property (p_usb) else $error("usb space");
endmodule
bind sfr_memory_map_decode sfr_memory_map_decode_assertions chk_i (.*);
`default_nettype wire

// File: verif/sfr_memory_map_decode_tb.sv
// self-checking bench for the register bank decode
`timescale 1ns/1ns
`default_nettype none
module sfr_memory_map_decode_tb
	import sfr_map_pkg::*;
;
	logic clk_sys = 0, reset = 1, flash_32k = 0, xaddr_valid = 0;
	logic xaddr_movc = 0, xaddr_prot = 0, sfr_rd, sfr_wr, sfr_bit, sfr_hit;
	logic sfr_bit_err, idata_sel, xprot_viol;
	logic [ADDR_W-1:0] xaddr = '0;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, q;
	logic [7:0] memory_cycle_control, clock_control_reg, flash_command_reg;
	logic [2:0] xspace, sfr_bit_sel;
	logic [15:0] xa [5] = '{16'h0002, 16'h4000, 16'h8100, 16'hc7ff, 16'hf000};
	int err_total = 0, checks_done = 0;
	sfr_memory_map_decode sfr_memory_map_decode_i (.*);
	core_access_model core_access_model_i (.*);
	initial forever #25 clk_sys = ~clk_sys;
	task automatic chk(input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d, input logic b = 1'b0,
		input logic [2:0] s = 3'h0);
		core_access_model_i.acc(1'b0, 1'b1, b, s, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic b = 1'b0,
		input logic [2:0] s = 3'h0);
		core_access_model_i.acc(1'b1, 1'b0, b, s, a, 8'h00, q);
	endtask
	task automatic conclude;
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#200000;
		err_total++;
		conclude();
	end
	initial
	begin
		repeat (12) @(negedge clk_sys);
		reset = 0;
		chk(memory_cycle_control, 8'h01);
		chk(clock_control_reg, 8'h80);
		for (int i = 0; i < NUM_REGS; i++)
			if (REG_HAS_RESET[i])
			begin
				rd(REG_ADDR[i]);
				chk(q, REG_RESET[i]);
			end
		for (int i = 0; i < NUM_REGS; i++)
		begin
			wr(REG_ADDR[i], 8'h30 + i[7:0]);
			rd(REG_ADDR[i]);
			chk(q, 8'h30 + i[7:0]);
		end
		chk(flash_command_reg, 8'h4c);
		@(negedge clk_sys);
		reset = 1;
		@(negedge clk_sys);
		reset = 0;
		chk(flash_command_reg, 8'h00);
		rd(8'hf8);
		chk(q, 8'h4a);
		chk({7'h0, sfr_hit}, 8'h01);
		rd(8'hf9);
		chk(q, 8'h4b);
		wr(8'h84, 8'hff);
		rd(8'h84);
		chk(q, 8'h00);
		chk({7'h0, sfr_hit}, 8'h00);
		chk(memory_cycle_control, 8'h01);
		rd(8'h10);
		chk({7'h0, idata_sel}, 8'h01);
		wr(8'ha8, 8'h00);
		wr(8'ha8, 8'h01, 1'b1, 3'h3);
		rd(8'ha8);
		chk(q, 8'h08);
		rd(8'ha8, 1'b1, 3'h3);
		chk({7'h0, q[0]}, 8'h01);
		wr(8'ha3, 8'h00, 1'b1, 3'h7);
		chk({7'h0, sfr_bit_err}, 8'h01);
		chk(clock_control_reg, 8'h80);
		for (int v = 0; v < 2; v++)
			for (int k = 0; k < 5; k++)
			begin
				@(negedge clk_sys);
				{flash_32k, xaddr_valid, xaddr_movc, xaddr_prot} = {v[0], 3'h7};
				xaddr = xa[k];
				@(negedge clk_sys);
				chk({5'h0, xspace}, (k == 0 || k == 1 && v == 1) ? 8'h01 :
					k == 2 ? 8'h02 : k == 3 ? 8'h03 : 8'h00);
				chk({7'h0, xprot_viol}, {7'h0, k == 0});
			end
		conclude();
	end
endmodule
`default_nettype wire

// File: verilog/sfr_map_pkg.sv
// constants for the register bank and memory-space decode
// Summary of operation
// - one 64 KB shared code and data space
// - separate 256-byte internal data memory
// - 128-byte register area, decoded apart
// - map 16/32 KB flash plus 2 KB SRAM
// - reserve 2 KB for USB buffers, registers
// - low three bits zero: byte and bit access
// - other registers: byte access only
// - reset values 0x01, 0x80, 0x01, else zero
// - flash status, protection: no fixed reset value
// - flash registers at 0xf8, 0xf9, 0xfa
package sfr_map_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          NUM_REGS        = 29;
	localparam logic [16:0] CODE_SPACE_SIZE = 17'h10000;
	localparam logic [8:0]  IDATA_SIZE      = 9'h100;
	localparam logic [7:0]  SFR_BASE        = 8'h80;
	// flash size per variant: 16 KB or 32 KB
	localparam logic [15:0] FLASH_END_16K   = 16'h3fff;
	localparam logic [15:0] FLASH_END_32K   = 16'h7fff;
	localparam logic [15:0] SRAM_BASE       = 16'h8000;
	localparam logic [15:0] SRAM_END        = 16'h87ff;
	localparam logic [15:0] USB_BASE        = 16'hc000;
	localparam logic [15:0] USB_END         = 16'hc7ff;
	localparam logic [15:0] PROT_LOW_END    = 16'h0003;
	localparam logic [7:0]  FLASH_STATE_ADDR  = 8'hf8;
	localparam logic [7:0]  FLASH_PROT_ADDR   = 8'hf9;
	localparam logic [7:0]  FLASH_CMD_ADDR    = 8'hfa;
	// register offsets, in table order
	localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
		8'h82, 8'h83, 8'h8e, 8'h92, 8'ha3, 8'ha6, 8'ha8, 8'hb8,
		8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hca,
		8'hcb, 8'he0, 8'he8, 8'hef, 8'hf0, 8'hf1, 8'hf2, 8'hf3,
		8'hf5, 8'hf6, FLASH_STATE_ADDR, FLASH_PROT_ADDR,
		FLASH_CMD_ADDR};
	// reset values; the two flash entries are unfixed and held as-is
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{
		8'h00, 8'h00, 8'h01, 8'h00, 8'h80, 8'h01, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// flash status (26) and protection (27) keep content; command resets
	localparam logic [NUM_REGS-1:0] REG_HAS_RESET = 29'h13ffffff;
	localparam int IDX_CYCLE_CTRL = 2;
	localparam int IDX_CLOCK_CTRL = 4;
	localparam int IDX_FLASH_CMD  = 28;
	typedef enum logic [2:0]
	{
		SPACE_NONE  = 3'b000,
		SPACE_FLASH = 3'b001,
		SPACE_SRAM  = 3'b010,
		SPACE_USB   = 3'b011
	} space_t;
endpackage

// File: verilog/sfr_memory_map_decode.sv
// register bank and address-space decode for the processor core
`timescale 1ns/1ns
`default_nettype none
module sfr_memory_map_decode
	import sfr_map_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              flash_32k,
	input  wire logic [ADDR_W-1:0] xaddr,
	input  wire logic              xaddr_valid,
	input  wire logic              xaddr_movc,
	input  wire logic              xaddr_prot,
	input  wire logic [7:0]        sfr_addr,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic              sfr_bit,
	input  wire logic [2:0]        sfr_bit_sel,
	input  wire logic [7:0]        sfr_wdata,
	output logic [7:0]             sfr_rdata,
	output logic                   sfr_hit,
	output logic                   sfr_bit_err,
	output logic                   idata_sel,
	output logic [2:0]             xspace,
	output logic                   xprot_viol,
	output logic [7:0]             memory_cycle_control,
	output logic [7:0]             clock_control_reg,
	output logic [7:0]             flash_command_reg
);

typedef struct packed
{
	logic [NUM_REGS-1:0][7:0] regs;
	logic [7:0]               rdata;
	logic                     hit;
	logic                     bit_err;
	logic                     idata;
	logic [2:0]               space;
	logic                     prot_viol;
} state_t;

state_t st_ff;
state_t nxt_st;

////////////////////////////////////////////////////////////////////////////
// decode functions

function automatic logic [NUM_REGS-1:0] reg_match(input logic [7:0] a);
	logic [NUM_REGS-1:0] m;
	m = '0;
	for (int i = 0; i < NUM_REGS; i++)
	begin
		m[i] = (a == REG_ADDR[i]);
	end
	return m;
endfunction

// only addresses ending in 000 allow bit access
function automatic logic bit_ok(input logic [7:0] a);
	return a[2:0] == 3'b000;
endfunction

////////////////////////////////////////////////////////////////////////////
// next state

always_comb
begin
	logic [NUM_REGS-1:0] m;
	logic                is_bit;
	logic [7:0]          v;
	m      = reg_match(sfr_addr);
	is_bit = sfr_bit && bit_ok(sfr_addr);
	v      = 8'h00;
	nxt_st = st_ff;
	nxt_st.bit_err = sfr_bit && (sfr_rd || sfr_wr) && !bit_ok(sfr_addr);
	nxt_st.hit     = (|m) && (sfr_rd || sfr_wr);
	nxt_st.rdata   = 8'h00;
	for (int i = 0; i < NUM_REGS; i++)
	begin
		if (m[i])
		begin
			v = st_ff.regs[i];
		end
	end
	if (sfr_rd)
	begin
		nxt_st.rdata = is_bit ? {7'h00, v[sfr_bit_sel]} : v;
		if (sfr_bit && !bit_ok(sfr_addr))
		begin
			nxt_st.rdata = 8'h00;
		end
	end
	if (sfr_wr && !(sfr_bit && !bit_ok(sfr_addr)))
	begin
		for (int i = 0; i < NUM_REGS; i++)
		begin
			if (m[i])
			begin
				if (is_bit)
				begin
					nxt_st.regs[i][sfr_bit_sel] = sfr_wdata[0];
				end
				else
				begin
					nxt_st.regs[i] = sfr_wdata;
				end
			end
		end
	end
	// direct addresses below the register area hit internal memory
	nxt_st.idata = (sfr_rd || sfr_wr) && (sfr_addr < SFR_BASE);
	// external/code space decode
	nxt_st.space     = SPACE_NONE;
	nxt_st.prot_viol = 1'b0;
	if (xaddr_valid)
	begin
		if (xaddr <= (flash_32k ? FLASH_END_32K : FLASH_END_16K))
		begin
			nxt_st.space = SPACE_FLASH;
		end
		else if (xaddr >= SRAM_BASE && xaddr <= SRAM_END)
		begin
			nxt_st.space = SPACE_SRAM;
		end
		else if (xaddr >= USB_BASE && xaddr <= USB_END)
		begin
			nxt_st.space = SPACE_USB;
		end
		nxt_st.prot_viol = xaddr_movc && xaddr_prot
			&& (xaddr <= PROT_LOW_END);
	end
	if (reset)
	begin
		for (int i = 0; i < NUM_REGS; i++)
		begin
			if (REG_HAS_RESET[i])
			begin
				nxt_st.regs[i] = REG_RESET[i];
			end
		end
		// flash status and protection keep their content
		nxt_st.rdata     = 8'h00;
		nxt_st.hit       = 1'b0;
		nxt_st.bit_err   = 1'b0;
		nxt_st.idata     = 1'b0;
		nxt_st.space     = SPACE_NONE;
		nxt_st.prot_viol = 1'b0;
	end
end

always_ff @(posedge clk_sys)
begin
	st_ff <= nxt_st;
end

////////////////////////////////////////////////////////////////////////////
// outputs

assign sfr_rdata            = st_ff.rdata;
assign sfr_hit              = st_ff.hit;
assign sfr_bit_err          = st_ff.bit_err;
assign idata_sel            = st_ff.idata;
assign xspace               = st_ff.space;
assign xprot_viol           = st_ff.prot_viol;
assign memory_cycle_control = st_ff.regs[IDX_CYCLE_CTRL];
assign clock_control_reg    = st_ff.regs[IDX_CLOCK_CTRL];
assign flash_command_reg    = st_ff.regs[IDX_FLASH_CMD];

endmodule
`default_nettype wire
